//--- src/impl_ctrl_regs.svh
// mask, field positions, reset value and counts of the implementation control bits
`ifndef IMPL_CTRL_REGS_SVH
`define IMPL_CTRL_REGS_SVH

`define IC_BIT_LIGHT_IDLE      9
`define IC_BIT_SLEEP           10
`define IC_BIT_AUTO_GATING     11
`define IC_BIT_SOFT_MARKER     15
`define IC_BIT_INSTR_ON        16
`define IC_BIT_DATA_ON         17
`define IC_BIT_INSTR_FREEZE    18
`define IC_BIT_DATA_FREEZE     19

`define IC_IMPL_MASK           32'h000f_8e00
`define IC_RESET_VALUE         32'h0000_0000

`define IC_SLEEP_ENTRY_CYCLES  4'h8
`define IC_PLL_BYPASS_CFG      4'hf
`define IC_UNIT_COUNT          8

`endif

//--- src/impl_ctrl_pkg.sv
// types shared by the implementation control bits
package impl_ctrl_pkg;
    typedef enum logic [2:0] {
        PWR_RUN,
        PWR_LIGHT_IDLE,
        PWR_QUIESCE_REQ,
        PWR_SLEEP_ENTRY,
        PWR_SLEEP
    } power_state_t;

    typedef struct packed {
        power_state_t st;
        logic [3:0]   cnt;
        logic         light_idle;
        logic         quiesce_req;
        logic         asleep;
        logic         pll_stop_ok;
    } power_fsm_t;

    typedef struct packed {
        logic lookup;
        logic hit_serve;
        logic fill;
        logic single_beat;
        logic ci;
        logic snoop_take;
    } policy_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [7:0]  unit_low_power;
    } top_state_t;
endpackage

//--- src/power_mode_fsm.sv
// light-idle and sleep sequencing with the quiesce handshake
`timescale 1ns/10ps
`default_nettype none
`include "impl_ctrl_regs.svh"
module power_mode_fsm
    import impl_ctrl_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       light_idle_en_in,
    input  wire logic       sleep_en_in,
    input  wire logic       power_save_request_in,
    input  wire logic       quiesce_grant_in,
    input  wire logic [3:0] pll_cfg_in,
    output var  logic       light_idle_out,
    output var  logic       quiesce_request_out,
    output var  logic       sleep_out,
    output var  logic       pll_stop_ok_out
);
    power_fsm_t s_r;
    power_fsm_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        case (s_r.st)
            PWR_RUN:
            begin
                if (power_save_request_in && sleep_en_in)
                    s_nxt.st = PWR_QUIESCE_REQ; // R2
                else if (power_save_request_in && light_idle_en_in)
                    s_nxt.st = PWR_LIGHT_IDLE; // R1
            end
            PWR_LIGHT_IDLE:
            begin
                if (!power_save_request_in)
                    s_nxt.st = PWR_RUN;
            end
            PWR_QUIESCE_REQ:
            begin
                s_nxt.cnt = 4'h0;
                if (!power_save_request_in)
                    s_nxt.st = PWR_RUN;
                else if (quiesce_grant_in)
                    s_nxt.st = PWR_SLEEP_ENTRY; // R4
            end
            PWR_SLEEP_ENTRY:
            begin
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (!power_save_request_in)
                    s_nxt.st = PWR_RUN;
                else if (s_r.cnt == `IC_SLEEP_ENTRY_CYCLES - 4'h1)
                    s_nxt.st = PWR_SLEEP; // R4
            end
            PWR_SLEEP:
            begin
                if (!power_save_request_in)
                    s_nxt.st = PWR_RUN;
            end
            default:
                s_nxt.st = PWR_RUN;
        endcase
        s_nxt.light_idle  = (s_nxt.st == PWR_LIGHT_IDLE);
        s_nxt.quiesce_req = (s_nxt.st == PWR_QUIESCE_REQ) || (s_nxt.st == PWR_SLEEP_ENTRY)
                            || (s_nxt.st == PWR_SLEEP);
        s_nxt.asleep      = (s_nxt.st == PWR_SLEEP);
        s_nxt.pll_stop_ok = s_nxt.asleep && (pll_cfg_in == `IC_PLL_BYPASS_CFG); // R5
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            s_r <= '{st: PWR_RUN, default: '0};
        else
            s_r <= s_nxt;
    end

    assign light_idle_out      = s_r.light_idle;
    assign quiesce_request_out = s_r.quiesce_req;
    assign sleep_out           = s_r.asleep;
    assign pll_stop_ok_out     = s_r.pll_stop_ok;
endmodule // power_mode_fsm
`default_nettype wire

//--- src/l1_access_policy.sv
// steering of one l1 cache by its enable and freeze bits
`timescale 1ns/10ps
`default_nettype none
module l1_access_policy
    import impl_ctrl_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic cache_on_in,
    input  wire logic cache_freeze_in,
    input  wire logic access_in,
    input  wire logic hit_in,
    input  wire logic xlat_ci_in,
    input  wire logic snoop_in,
    input  wire logic snoop_hit_in,
    output var  logic lookup_out,
    output var  logic hit_serve_out,
    output var  logic fill_out,
    output var  logic single_beat_out,
    output var  logic ci_out,
    output var  logic snoop_take_out
);
    policy_t p_r;
    policy_t p_nxt;
    logic    use_tags;

    always_comb
    begin
        use_tags           = access_in && cache_on_in; // R8 R9 R10
        p_nxt.lookup       = use_tags;
        p_nxt.hit_serve    = use_tags && hit_in; // R13 R14
        p_nxt.fill         = use_tags && !hit_in && !cache_freeze_in; // R13 R14 R16
        p_nxt.single_beat  = access_in && (!cache_on_in || (!hit_in && cache_freeze_in)); // R10
        p_nxt.ci           = access_in && xlat_ci_in; // R11
        p_nxt.snoop_take   = snoop_in && snoop_hit_in && cache_on_in; // R15
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            p_r <= '0;
        else
            p_r <= p_nxt;
    end

    assign lookup_out      = p_r.lookup;
    assign hit_serve_out   = p_r.hit_serve;
    assign fill_out        = p_r.fill;
    assign single_beat_out = p_r.single_beat;
    assign ci_out          = p_r.ci;
    assign snoop_take_out  = p_r.snoop_take;
endmodule // l1_access_policy
`default_nettype wire

//--- src/power_and_l1_cache_control_bits.sv
// power mode and l1 cache control bits of the implementation control register
// How it works
// R1: light-idle bit plus power request enters idle, unless the sleep bit is also set
// R2: sleep bit plus power request raises quiesce request
// R3: outside logic answers request with quiesce grant
// R4: after grant, sleep follows fixed cycles later
// R5: outside logic bypasses pll before stopping clock
// R6: auto gating bit idles unused units
// R7: marker survives soft reset, hard reset clears
// R8: instruction cache off: no lookup, fill, snoop
// R9: data cache off: no lookup, fill, snoop
// R10: disabled cache forwards single-beat transactions
// R11: cache inhibit output follows address translation
// R12: both cache enables clear at power-up
// R13: instruction freeze serves hits, misses not allocated
// R14: data freeze serves hits, misses not allocated
// R15: snoop hits locked data cache normally
// R16: snooped-out block stays invalid while frozen
// R17: software syncs before setting either freeze bit
`timescale 1ns/10ps
`default_nettype none
`include "impl_ctrl_regs.svh"
module power_and_l1_cache_control_bits
    import impl_ctrl_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        soft_rst_in,
    input  wire logic        spr_wr_in,
    input  wire logic [31:0] spr_wdata_in,
    output var  logic [31:0] spr_rdata_out,
    input  wire logic        power_save_request_in,
    input  wire logic        quiesce_grant_in,
    input  wire logic [3:0]  pll_cfg_in,
    output var  logic        light_idle_out,
    output var  logic        quiesce_request_out,
    output var  logic        sleep_out,
    output var  logic        pll_stop_ok_out,
    input  wire logic [7:0]  unit_idle_in,
    output var  logic [7:0]  unit_low_power_out,
    input  wire logic        i_access_in,
    input  wire logic        i_hit_in,
    input  wire logic        i_xlat_ci_in,
    input  wire logic        i_snoop_in,
    input  wire logic        i_snoop_hit_in,
    output var  logic        i_lookup_out,
    output var  logic        i_hit_serve_out,
    output var  logic        i_fill_out,
    output var  logic        i_single_beat_out,
    output var  logic        i_cache_inhibit_out,
    output var  logic        i_snoop_take_out,
    input  wire logic        d_access_in,
    input  wire logic        d_hit_in,
    input  wire logic        d_xlat_ci_in,
    input  wire logic        d_snoop_in,
    input  wire logic        d_snoop_hit_in,
    output var  logic        d_lookup_out,
    output var  logic        d_hit_serve_out,
    output var  logic        d_fill_out,
    output var  logic        d_single_beat_out,
    output var  logic        d_cache_inhibit_out,
    output var  logic        d_snoop_take_out
);
    // ****************************************
    // control register
    // ****************************************
    top_state_t s_r;
    top_state_t s_nxt;
    logic       fsm_rst;

    function automatic logic [31:0] keep_marker(input logic [31:0] v);
        keep_marker = `IC_RESET_VALUE;
        keep_marker[`IC_BIT_SOFT_MARKER] = v[`IC_BIT_SOFT_MARKER];
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        if (soft_rst_in)
            s_nxt.ctrl = keep_marker(s_r.ctrl); // R7
        else if (spr_wr_in)
            s_nxt.ctrl = spr_wdata_in & `IC_IMPL_MASK; // R17
        s_nxt.rdata = s_nxt.ctrl;
        if (s_r.ctrl[`IC_BIT_AUTO_GATING])
            s_nxt.unit_low_power = unit_idle_in; // R6
        else
            s_nxt.unit_low_power = 8'h00;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            s_r <= '0; // R7 R12
        else
            s_r <= s_nxt;
    end

    assign spr_rdata_out      = s_r.rdata;
    assign unit_low_power_out = s_r.unit_low_power;
    assign fsm_rst            = sys_rst_in || soft_rst_in;

    // ****************************************
    // power modes
    // ****************************************
    power_mode_fsm u_power
    (
        .clk_in                (clk_in),
        .sys_rst_in            (fsm_rst),
        .light_idle_en_in      (s_r.ctrl[`IC_BIT_LIGHT_IDLE]),
        .sleep_en_in           (s_r.ctrl[`IC_BIT_SLEEP]),
        .power_save_request_in (power_save_request_in),
        .quiesce_grant_in      (quiesce_grant_in),
        .pll_cfg_in            (pll_cfg_in),
        .light_idle_out        (light_idle_out),
        .quiesce_request_out   (quiesce_request_out),
        .sleep_out             (sleep_out),
        .pll_stop_ok_out       (pll_stop_ok_out)
    );

    // ****************************************
    // l1 caches
    // ****************************************
    l1_access_policy u_icache
    (
        .clk_in          (clk_in),
        .sys_rst_in      (sys_rst_in),
        .cache_on_in     (s_r.ctrl[`IC_BIT_INSTR_ON]),
        .cache_freeze_in (s_r.ctrl[`IC_BIT_INSTR_FREEZE]),
        .access_in       (i_access_in),
        .hit_in          (i_hit_in),
        .xlat_ci_in      (i_xlat_ci_in),
        .snoop_in        (i_snoop_in),
        .snoop_hit_in    (i_snoop_hit_in),
        .lookup_out      (i_lookup_out),
        .hit_serve_out   (i_hit_serve_out),
        .fill_out        (i_fill_out),
        .single_beat_out (i_single_beat_out),
        .ci_out          (i_cache_inhibit_out),
        .snoop_take_out  (i_snoop_take_out)
    );

    l1_access_policy u_dcache
    (
        .clk_in          (clk_in),
        .sys_rst_in      (sys_rst_in),
        .cache_on_in     (s_r.ctrl[`IC_BIT_DATA_ON]),
        .cache_freeze_in (s_r.ctrl[`IC_BIT_DATA_FREEZE]),
        .access_in       (d_access_in),
        .hit_in          (d_hit_in),
        .xlat_ci_in      (d_xlat_ci_in),
        .snoop_in        (d_snoop_in),
        .snoop_hit_in    (d_snoop_hit_in),
        .lookup_out      (d_lookup_out),
        .hit_serve_out   (d_hit_serve_out),
        .fill_out        (d_fill_out),
        .single_beat_out (d_single_beat_out),
        .ci_out          (d_cache_inhibit_out),
        .snoop_take_out  (d_snoop_take_out)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in || soft_rst_in);

    light_idle_entry_a: assert property ( // R1
        (s_r.ctrl[`IC_BIT_LIGHT_IDLE] && !s_r.ctrl[`IC_BIT_SLEEP] && power_save_request_in
         && !spr_wr_in)[*2]
        |-> light_idle_out)
        else $error("light idle not entered");

    quiesce_raise_a: assert property ( // R2
        (s_r.ctrl[`IC_BIT_SLEEP] && power_save_request_in && !spr_wr_in)[*2]
        |-> quiesce_request_out)
        else $error("quiesce request missing");

    sleep_after_grant_a: assert property ( // R4
        (quiesce_request_out && quiesce_grant_in && !sleep_out && power_save_request_in)
        ##1 power_save_request_in[*8] ##1 power_save_request_in
        |-> sleep_out)
        else $error("sleep not reached after grant");

    sleep_not_early_a: assert property ( // R4
        $rose(quiesce_request_out) |-> !sleep_out[*8])
        else $error("sleep entered too early");

    pll_stop_gate_a: assert property ( // R5
        pll_stop_ok_out |-> sleep_out)
        else $error("pll stop flagged while awake");

    pll_stop_set_a: assert property ( // R5
        sleep_out && power_save_request_in && pll_cfg_in == `IC_PLL_BYPASS_CFG
        |=> pll_stop_ok_out)
        else $error("pll stop not flagged in bypass");

    light_idle_exit_a: assert property ( // R1
        light_idle_out && !power_save_request_in
        |=> !light_idle_out)
        else $error("light idle held without request");

    power_drop_exit_a: assert property ( // R2 R4
        !power_save_request_in
        |=> !light_idle_out && !quiesce_request_out && !sleep_out)
        else $error("power mode held without request");

    sleep_over_idle_a: assert property ( // R2
        !light_idle_out && s_r.ctrl[`IC_BIT_SLEEP]
        |=> !light_idle_out)
        else $error("light idle chosen over sleep");

    grant_ignored_a: assert property ( // R4
        !quiesce_request_out
        |=> !sleep_out)
        else $error("sleep entered without quiesce request");

    soft_reset_bits_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R7
        soft_rst_in
        |=> (s_r.ctrl & ~(32'h0000_0001 << `IC_BIT_SOFT_MARKER)) == 32'h0000_0000
            && !light_idle_out && !quiesce_request_out)
        else $error("soft reset left bits set");

    auto_gate_off_a: assert property ( // R6
        !s_r.ctrl[`IC_BIT_AUTO_GATING] |=> unit_low_power_out == 8'h00)
        else $error("unit gated while auto gating off");

    auto_gate_on_a: assert property ( // R6
        s_r.ctrl[`IC_BIT_AUTO_GATING] |=> unit_low_power_out == $past(unit_idle_in))
        else $error("idle unit not gated");

    marker_soft_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R7
        soft_rst_in && s_r.ctrl[`IC_BIT_SOFT_MARKER] |=> s_r.ctrl[`IC_BIT_SOFT_MARKER])
        else $error("marker lost on soft reset");

    hard_reset_clear_a: assert property (@(posedge clk_in) disable iff (1'b0) // R7 R12
        sys_rst_in |=> s_r.ctrl == `IC_RESET_VALUE && spr_rdata_out == 32'h0000_0000)
        else $error("hard reset left bits set");

    // ****************************************
    // cache policy checks
    // ****************************************

    icache_off_idle_a: assert property ( // R8
        i_access_in && !s_r.ctrl[`IC_BIT_INSTR_ON]
        |=> !i_lookup_out && !i_fill_out && i_single_beat_out)
        else $error("disabled instruction cache used");

    dcache_off_idle_a: assert property ( // R9 R10
        (d_access_in || d_snoop_in) && !s_r.ctrl[`IC_BIT_DATA_ON]
        |=> !d_lookup_out && !d_fill_out && !d_snoop_take_out)
        else $error("disabled data cache used");

    ci_passthrough_a: assert property ( // R11
        d_access_in |=> d_cache_inhibit_out == $past(d_xlat_ci_in))
        else $error("cache inhibit forced by cache state");

    ifreeze_miss_a: assert property ( // R13
        i_access_in && !i_hit_in && s_r.ctrl[`IC_BIT_INSTR_ON] && s_r.ctrl[`IC_BIT_INSTR_FREEZE]
        |=> !i_fill_out && i_single_beat_out)
        else $error("frozen instruction miss allocated");

    dfreeze_hit_a: assert property ( // R14
        d_access_in && d_hit_in && s_r.ctrl[`IC_BIT_DATA_ON] && s_r.ctrl[`IC_BIT_DATA_FREEZE]
        |=> d_hit_serve_out && !d_single_beat_out)
        else $error("frozen data hit not served");

    locked_snoop_a: assert property ( // R15 R16
        d_snoop_in && d_snoop_hit_in && s_r.ctrl[`IC_BIT_DATA_ON]
        |=> d_snoop_take_out)
        else $error("snoop refused on locked data cache");

    icache_snoop_off_a: assert property ( // R8
        i_snoop_in && !s_r.ctrl[`IC_BIT_INSTR_ON]
        |=> !i_snoop_take_out && !i_hit_serve_out)
        else $error("disabled instruction cache snooped");

    dcache_single_a: assert property ( // R10
        d_access_in && !s_r.ctrl[`IC_BIT_DATA_ON]
        |=> d_single_beat_out && !d_hit_serve_out)
        else $error("disabled data cache access not single-beat");

    icache_ci_a: assert property ( // R11
        i_access_in
        |=> i_cache_inhibit_out == $past(i_xlat_ci_in))
        else $error("instruction cache inhibit forced");

    ifreeze_hit_a: assert property ( // R13
        i_access_in && i_hit_in && s_r.ctrl[`IC_BIT_INSTR_ON] && s_r.ctrl[`IC_BIT_INSTR_FREEZE]
        |=> i_hit_serve_out && !i_single_beat_out)
        else $error("frozen instruction hit not served");

    dfreeze_miss_a: assert property ( // R14 R16
        d_access_in && !d_hit_in && s_r.ctrl[`IC_BIT_DATA_ON] && s_r.ctrl[`IC_BIT_DATA_FREEZE]
        |=> !d_fill_out && d_single_beat_out)
        else $error("frozen data miss allocated");

    dmiss_fill_a: assert property ( // R16
        d_access_in && !d_hit_in && s_r.ctrl[`IC_BIT_DATA_ON] && !s_r.ctrl[`IC_BIT_DATA_FREEZE]
        |=> d_fill_out && !d_single_beat_out)
        else $error("unfrozen data miss not filled");

    sleep_reached_c: cover property (
        quiesce_request_out ##1 quiesce_grant_in ##[1:12] sleep_out);

    light_idle_c: cover property ($rose(light_idle_out));

    frozen_miss_c: cover property (
        d_access_in && !d_hit_in && s_r.ctrl[`IC_BIT_DATA_FREEZE] ##1 d_single_beat_out);

    soft_keep_c: cover property (
        s_r.ctrl[`IC_BIT_SOFT_MARKER] && soft_rst_in);

    ifrozen_hit_c: cover property (
        i_access_in && i_hit_in && s_r.ctrl[`IC_BIT_INSTR_FREEZE] ##1 i_hit_serve_out);
endmodule // power_and_l1_cache_control_bits
`default_nettype wire

//--- bench/quiesce_partner.sv
// model of the system logic on the far side of the quiesce handshake
`timescale 1ns/10ps
`default_nettype none
`include "impl_ctrl_regs.svh"
module quiesce_partner #(
    parameter int         GRANT_DELAY = 3,
    parameter logic [3:0] RUN_CFG     = 4'h3
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       quiesce_request_in,
    input  wire logic       sleep_in,
    input  wire logic       force_grant_in,
    output var  logic       quiesce_grant_out,
    output var  logic [3:0] pll_cfg_out,
    output var  logic       clock_stop_out
);
    int wait_r;
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            wait_r            <= 0;
            quiesce_grant_out <= 1'b0;
            pll_cfg_out       <= RUN_CFG;
            clock_stop_out    <= 1'b0;
        end
        else
        begin
            // grant only after a request was seen, or when told to misbehave
            wait_r            <= quiesce_request_in ? wait_r + 1 : 0;
            quiesce_grant_out <= force_grant_in
                               | (quiesce_request_in && wait_r >= GRANT_DELAY);
            // bypass first, clock stop only afterwards
            pll_cfg_out       <= sleep_in ? `IC_PLL_BYPASS_CFG : RUN_CFG;
            clock_stop_out    <= sleep_in && pll_cfg_out == `IC_PLL_BYPASS_CFG;
        end
    end
endmodule // quiesce_partner
`default_nettype wire

//--- bench/power_and_l1_cache_control_bits_tb.sv
// self-checking bench of the power and l1 cache control bits
`timescale 1ns/10ps
`default_nettype none
module power_and_l1_cache_control_bits_tb;
    logic        clk_in, sys_rst_in, soft_rst_in, spr_wr_in, power_save_request, force_grant;
    logic [31:0] spr_wdata_in, rdata;
    logic        grant, light_idle, quiesce_request, sleep, stop_ok, clk_stop;
    logic [3:0]  pll_cfg;
    logic [7:0]  idle_units, low_power;
    logic [4:0]  i_in, d_in;
    wire  [5:0]  i_o, d_o;
    int          bad_count, total_checks;

    power_and_l1_cache_control_bits dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_rst_in(soft_rst_in),
        .spr_wr_in(spr_wr_in), .spr_wdata_in(spr_wdata_in), .spr_rdata_out(rdata),
        .power_save_request_in(power_save_request), .quiesce_grant_in(grant), .pll_cfg_in(pll_cfg),
        .light_idle_out(light_idle), .quiesce_request_out(quiesce_request), .sleep_out(sleep),
        .pll_stop_ok_out(stop_ok), .unit_idle_in(idle_units),
        .unit_low_power_out(low_power),
        .i_access_in(i_in[4]), .i_hit_in(i_in[3]), .i_xlat_ci_in(i_in[2]),
        .i_snoop_in(i_in[1]), .i_snoop_hit_in(i_in[0]),
        .i_lookup_out(i_o[5]), .i_hit_serve_out(i_o[4]), .i_fill_out(i_o[3]),
        .i_single_beat_out(i_o[2]), .i_cache_inhibit_out(i_o[1]),
        .i_snoop_take_out(i_o[0]),
        .d_access_in(d_in[4]), .d_hit_in(d_in[3]), .d_xlat_ci_in(d_in[2]),
        .d_snoop_in(d_in[1]), .d_snoop_hit_in(d_in[0]),
        .d_lookup_out(d_o[5]), .d_hit_serve_out(d_o[4]), .d_fill_out(d_o[3]),
        .d_single_beat_out(d_o[2]), .d_cache_inhibit_out(d_o[1]),
        .d_snoop_take_out(d_o[0])
    );

    quiesce_partner partner (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .quiesce_request_in(quiesce_request),
        .sleep_in(sleep), .force_grant_in(force_grant), .quiesce_grant_out(grant),
        .pll_cfg_out(pll_cfg), .clock_stop_out(clk_stop)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [31:0] d);
        @(posedge clk_in);
        spr_wr_in    <= 1'b1;
        spr_wdata_in <= d;
        @(posedge clk_in);
        spr_wr_in    <= 1'b0;
        #1;
    endtask

    task automatic hard_reset(input int n);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (n) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
    endtask

    // one access or snoop on one cache, answer judged one cycle later
    task automatic pol(input logic sel, input logic on, input logic frz, input logic [4:0] v);
        logic [5:0] e;
        if (on)
            e = {v[4], v[4] & v[3], v[4] & !v[3] & !frz, v[4] & !v[3] & frz,
                 v[4] & v[2], v[1] & v[0]};
        else
            e = {3'b000, v[4], v[4] & v[2], 1'b0};
        @(posedge clk_in);
        if (sel) d_in <= v;
        else i_in <= v;
        @(posedge clk_in);
        i_in <= 5'h00;
        d_in <= 5'h00;
        #1;
        chk(sel ? "d_policy" : "i_policy", {26'h0, e}, {26'h0, sel ? d_o : i_o});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reg_test();
        chk("rdata_reset", 32'h0000_0000, rdata);
        chk("power_reset", 32'h0, {light_idle, quiesce_request, sleep, stop_ok});
        wr(32'hffff_ffff);
        chk("rdata_mask", 32'h000f_8e00, rdata);
        wr(32'h0003_8000);
        chk("rdata_wr", 32'h0003_8000, rdata);
        @(posedge clk_in);
        soft_rst_in <= 1'b1;
        @(posedge clk_in);
        soft_rst_in <= 1'b0;
        #1;
        chk("rdata_soft", 32'h0000_8000, rdata);
        hard_reset(2);
        chk("rdata_hard", 32'h0000_0000, rdata);
    endtask

    task automatic idle_test();
        wr(32'h0000_0200);
        @(posedge clk_in);
        power_save_request <= 1'b1;
        cyc(1);
        chk("light_idle", 32'h1, {quiesce_request, light_idle});
        @(posedge clk_in);
        power_save_request <= 1'b0;
        cyc(1);
        chk("light_exit", 32'h0, {30'h0, quiesce_request, light_idle});
        wr(32'h0000_0600);
        @(posedge clk_in);
        power_save_request <= 1'b1;
        cyc(1);
        chk("sleep_first", 32'h2, {quiesce_request, light_idle});
        @(posedge clk_in);
        power_save_request <= 1'b0;
        cyc(1);
        chk("sleep_first_exit", 32'h0, {quiesce_request, light_idle});
    endtask

    task automatic sleep_test();
        int n;
        wr(32'h0000_0400);
        @(posedge clk_in);
        force_grant <= 1'b1;
        cyc(12);
        chk("grant_refused", 32'h0, {quiesce_request, sleep});
        force_grant <= 1'b0;
        power_save_request <= 1'b1;
        cyc(1);
        chk("quiesce_request", 32'h1, {light_idle, quiesce_request});
        n = 0;
        while (grant !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        n = 0;
        while (sleep !== 1'b1 && n < 30)
        begin
            cyc(1);
            n++;
        end
        chk("sleep_delay", 32'h1, {31'h0, n >= 8 && n <= 10});
        cyc(3);
        chk("pll_stop", 32'h3f, {pll_cfg, stop_ok, clk_stop});
        @(posedge clk_in);
        power_save_request <= 1'b0;
        cyc(1);
        chk("sleep_exit", 32'h0, {quiesce_request, sleep, stop_ok});
    endtask

    task automatic gating_test();
        wr(32'h0000_0800);
        @(posedge clk_in);
        idle_units <= 8'ha5;
        cyc(1);
        chk("gating_on", 32'h0000_00a5, {24'h0, low_power});
        wr(32'h0000_0000);
        cyc(1);
        chk("gating_off", 32'h0, {24'h0, low_power});
        idle_units <= 8'h00;
    endtask

    task automatic cache_test();
        logic [4:0] vec [4];
        vec = '{5'b10000, 5'b11000, 5'b10100, 5'b00011};
        for (int s = 0; s < 2; s++)
            for (int m = 0; m < 3; m++)
            begin
                wr((m == 0) ? 32'h0 : (32'h1 << (16 + s)) | ((m == 2) << (18 + s)));
                for (int k = 0; k < 4; k++)
                    if (!(m == 1 && k == 2))
                        pol(s[0], m != 0, m == 2, vec[k]);
            end
    endtask

    // ************************************************************
    // clock, reset, sequence, watchdog
    // ************************************************************
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    initial
    begin
        #200us;
        bad_count++;
        report_and_stop();
    end

    initial
    begin
        bad_count    = 0;
        total_checks = 0;
        sys_rst_in   = 1'b1;
        soft_rst_in  = 1'b0;
        spr_wr_in    = 1'b0;
        spr_wdata_in = 32'h0;
        power_save_request          = 1'b0;
        force_grant  = 1'b0;
        idle_units   = 8'h00;
        i_in         = 5'h00;
        d_in         = 5'h00;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        cyc(1);
        reg_test();
        idle_test();
        sleep_test();
        gating_test();
        cache_test();
        report_and_stop();
    end
endmodule // power_and_l1_cache_control_bits_tb
`default_nettype wire
